//--- core/dlbc_map.svh
// Constant map for the local bus and core control block.
`ifndef DLBC_MAP_SVH
`define DLBC_MAP_SVH
`define DLBC_RESET_VECTOR 16'h0000
`define DLBC_INT_VECTOR 16'h0001
`define DLBC_LVL_VECTOR 16'h0005
`define DLBC_EDGE0_VECTOR 16'h0006
`define DLBC_NMI_VECTOR 16'h000a
`define DLBC_COEFFICIENT_ROM_LIMIT 16'h0200
`define DLBC_STACK_DEPTH 8
`define DLBC_OSC_DIV 2
`endif

//--- core/dlbc_pkg.sv
// Types shared by the local bus and core control block.
`default_nettype none
package dlbc_pkg;
    typedef enum logic [2:0] {
        DLBC_IDLE = 3'b000,
        DLBC_XFER = 3'b001,
        DLBC_HOLD = 3'b010,
        DLBC_HALT = 3'b011,
        DLBC_LOWP = 3'b100
    } dlbc_state_e;
    typedef logic [15:0] dlbc_word_t;
endpackage : dlbc_pkg
`default_nettype wire

//--- core/dlbc_sync.sv
// Two-stage synchroniser for a vector of pin inputs.
`default_nettype none
module dlbc_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] INIT = '0
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_reg;
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            meta_reg <= INIT;
            q <= INIT;
        end
        else
        begin
            meta_reg <= d;
            q <= meta_reg;
        end
    end
endmodule : dlbc_sync
`default_nettype wire

//--- core/dlbc_port.sv
// General port: interrupt controller or bit-wise parallel input/output.
`default_nettype none
module dlbc_port
    import dlbc_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic irq_mode,
    input wire logic [7:0] irq_mask,
    input wire logic [7:0] port_dir,
    input wire logic [7:0] port_wdata,
    input wire logic [7:0] pins_sync,
    input wire logic [3:0] edge_clr,
    output logic [3:0] edge_pend_reg,
    output logic level_req,
    output logic [7:0] port_out_reg,
    output logic [7:0] port_oe_n_reg,
    output logic [7:0] test_cond
);
    logic [3:0] prev_reg;
    assign level_req = irq_mode && |(~pins_sync[7:4] & irq_mask[7:4]);
    assign test_cond = pins_sync;
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            prev_reg <= 4'hf;
        else
            prev_reg <= pins_sync[3:0];
    end
    genvar i;
    generate
        for (i = 0; i < 4; i++)
        begin : g_edge
            // A new falling edge wins over a clear in the same cycle.
            always_ff @(posedge clk or negedge rstn)
            begin
                if (!rstn)
                    edge_pend_reg[i] <= 1'b0;
                else if (irq_mode && irq_mask[i] && prev_reg[i] && !pins_sync[i])
                    edge_pend_reg[i] <= 1'b1;
                else if (edge_clr[i])
                    edge_pend_reg[i] <= 1'b0;
            end
        end
    endgenerate
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            port_out_reg <= 8'h00;
            port_oe_n_reg <= 8'hff;
        end
        else
        begin
            port_out_reg <= port_wdata;
            port_oe_n_reg <= irq_mode ? 8'hff : ~port_dir;
        end
    end
    property p_edge_hold;
        @(posedge clk) disable iff (!rstn)
        edge_pend_reg[0] && !edge_clr[0] |=> edge_pend_reg[0];
    endproperty
    a_edge_hold: assert property (p_edge_hold)
        else $error("edge pending bit dropped without clear");
endmodule : dlbc_port
`default_nettype wire

//--- core/dlbc_core.sv
// Local bus, hold, halt, low power, clock and interrupt sequencing of the core.
//
// Summary of operation
// - Data lines float unless transfer is active
// - Address floats in hold, halt, low power
// - Strobe and direction; external acknowledge completes
// - Bus request active during each exchange
// - Hold frees bus; access then halts
// - Release acknowledge shown while in hold
// - Falling edge on edge pins interrupts
// - Low level on level pins interrupts
// - Port is interrupt or parallel, whole
// - Parallel bits individually directed, branch-testable
// - Machine clock is oscillator divided by two
// - General interrupt is active low, maskable
// - Reset loads zero, no-operation, resyncs clock
// - Low power stops after cycle, keeps state
// - Halt stops after instruction, floats buses
// - Non-maskable interrupt edge loads vector ten
// - Program address floats in halt, DMA
// - Coefficient flag marks emulated coefficient access
// - Marker falls at each instruction cycle
// - Interrupt pushes counter, loads fixed vector
// - Halt, hold, low power, wait stall sequencer
`include "dlbc_map.svh"
`default_nettype none
module dlbc_core
    import dlbc_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic hold_req,
    input wire logic halt_req,
    input wire logic low_power_req,
    input wire logic dma_active,
    input wire logic local_transfer_ack_n,
    input wire logic gen_irq_n,
    input wire logic nmi_n,
    input wire logic [7:0] general_port_pins_in,
    input wire logic [15:0] local_data_lines_in,
    input wire logic [31:0] program_data_bus,
    input wire logic acc_req,
    input wire logic acc_write,
    input wire logic [15:0] acc_addr,
    input wire logic [15:0] acc_wdata,
    input wire logic acc_coef,
    input wire logic cplx_mode,
    input wire logic irq_mode,
    input wire logic [7:0] irq_mask,
    input wire logic gen_irq_en,
    input wire logic [7:0] port_dir,
    input wire logic [7:0] port_wdata,
    input wire logic branch_req,
    input wire logic [15:0] branch_addr,
    input wire logic rti_req,
    output logic [15:0] local_data_lines_out,
    output logic [15:0] local_data_lines_oe_n,
    output logic [15:0] local_address_lines,
    output logic local_address_oe_n,
    output logic local_strobe_n,
    output logic local_rw,
    output logic local_bus_request_n,
    output logic bus_release_ack_n,
    output logic [7:0] general_port_pins_out,
    output logic [7:0] general_port_pins_oe_n,
    output logic [7:0] port_test_cond,
    output logic machine_clock_out,
    output logic [15:0] program_addr_bus,
    output logic program_addr_oe_n,
    output logic [31:0] instr_word,
    output logic coef_emulation_flag,
    output logic instr_cycle_marker,
    output logic [15:0] acc_rdata,
    output logic acc_done,
    output logic halted
);
    dlbc_state_e state_reg;
    logic hold_s, halt_s, lp_s, ack_n_s, int_n_s, nmi_n_s, nmi_prev_reg;
    logic [7:0] pins_s;
    logic [15:0] pc_reg;
    logic [15:0] stack_reg [`DLBC_STACK_DEPTH];
    logic [2:0] sp_reg;
    logic phase_reg, cyc_reg, nmi_pend_reg;
    logic [3:0] edge_pend, edge_clr;
    logic level_req, advance, instr_end;
    logic [7:0] pouts, poe;
    dlbc_sync #(.W(6), .INIT(6'b000111)) u_sync (
        .clk(clk),
        .rstn(rstn),
        .d({hold_req, halt_req, low_power_req, local_transfer_ack_n, gen_irq_n, nmi_n}),
        .q({hold_s, halt_s, lp_s, ack_n_s, int_n_s, nmi_n_s})
    );
    dlbc_sync #(.W(8), .INIT(8'hff)) u_psync (
        .clk(clk),
        .rstn(rstn),
        .d(general_port_pins_in),
        .q(pins_s)
    );
    dlbc_port u_port (
        .clk(clk),
        .rstn(rstn),
        .irq_mode(irq_mode),
        .irq_mask(irq_mask),
        .port_dir(port_dir),
        .port_wdata(port_wdata),
        .pins_sync(pins_s),
        .edge_clr(edge_clr),
        .edge_pend_reg(edge_pend),
        .level_req(level_req),
        .port_out_reg(pouts),
        .port_oe_n_reg(poe),
        .test_cond(port_test_cond)
    );
    assign general_port_pins_out = pouts;
    assign general_port_pins_oe_n = poe;
    // The oscillator is clk; the machine clock toggles each rising edge so it is half rate.
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            phase_reg <= 1'b0;
        else
            phase_reg <= ~phase_reg;
    end
    assign machine_clock_out = phase_reg;
    // One machine cycle ends on each high phase; complex mode takes two per instruction.
    assign advance = phase_reg && (state_reg == DLBC_IDLE) && !acc_req;
    assign instr_end = advance && (!cplx_mode || cyc_reg);
    // State machine for the local bus and the stop conditions.
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            state_reg <= DLBC_IDLE;
        else
        begin
            case (state_reg)
                DLBC_IDLE:
                    if (lp_s && phase_reg)
                        state_reg <= DLBC_LOWP;
                    else if (halt_s && (instr_end || !phase_reg && !cyc_reg))
                        state_reg <= DLBC_HALT;
                    else if (hold_s)
                        state_reg <= DLBC_HOLD;
                    else if (acc_req && !acc_done)
                        state_reg <= DLBC_XFER;
                DLBC_XFER:
                    if (!ack_n_s)
                        state_reg <= DLBC_IDLE;
                DLBC_HOLD:
                    if (acc_req)
                        state_reg <= DLBC_HALT;
                    else if (!hold_s)
                        state_reg <= DLBC_IDLE;
                DLBC_HALT:
                    if (!halt_s && !hold_s)
                        state_reg <= DLBC_IDLE;
                DLBC_LOWP:
                    if (!lp_s)
                        state_reg <= DLBC_IDLE;
                default:
                    state_reg <= DLBC_IDLE;
            endcase
        end
    end
    // Bus pins, all registered; acknowledge of hold follows the float by one edge.
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            local_data_lines_out <= 16'h0000;
            local_data_lines_oe_n <= 16'hffff;
            local_address_lines <= 16'h0000;
            local_address_oe_n <= 1'b0;
            local_strobe_n <= 1'b1;
            local_rw <= 1'b1;
            local_bus_request_n <= 1'b1;
            bus_release_ack_n <= 1'b1;
            coef_emulation_flag <= 1'b0;
            acc_rdata <= 16'h0000;
            acc_done <= 1'b0;
            halted <= 1'b0;
        end
        else
        begin
            local_data_lines_out <= acc_wdata;
            local_data_lines_oe_n <= (state_reg == DLBC_XFER && acc_write && !hold_s
                && !halt_s && !lp_s) ? 16'h0000 : 16'hffff;
            local_address_lines <= acc_addr;
            local_address_oe_n <= (hold_s || halt_s || lp_s
                || state_reg inside {DLBC_HOLD, DLBC_HALT, DLBC_LOWP});
            local_strobe_n <= !(state_reg == DLBC_XFER && ack_n_s);
            local_rw <= !(state_reg == DLBC_XFER && acc_write);
            local_bus_request_n <= !(state_reg == DLBC_XFER && ack_n_s);
            bus_release_ack_n <= !(state_reg == DLBC_HOLD && local_address_oe_n
                && &local_data_lines_oe_n);
            coef_emulation_flag <= state_reg == DLBC_XFER && acc_coef
                && acc_addr < `DLBC_COEFFICIENT_ROM_LIMIT;
            acc_done <= state_reg == DLBC_XFER && !ack_n_s;
            if (state_reg == DLBC_XFER && !ack_n_s && !acc_write)
                acc_rdata <= local_data_lines_in;
            halted <= state_reg == DLBC_HALT;
        end
    end
    // Instruction sequencer: counter, stack, interrupt vectors.
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            nmi_prev_reg <= 1'b1;
            nmi_pend_reg <= 1'b0;
        end
        else
        begin
            nmi_prev_reg <= nmi_n_s;
            if (nmi_prev_reg && !nmi_n_s)
                nmi_pend_reg <= 1'b1;
            else if (instr_end)
                nmi_pend_reg <= 1'b0;
        end
    end
    always_comb
    begin
        edge_clr = 4'h0;
        if (instr_end && !nmi_pend_reg && !(gen_irq_en && !int_n_s) && !level_req)
        begin
            if (edge_pend[0])
                edge_clr = 4'h1;
            else if (edge_pend[1])
                edge_clr = 4'h2;
            else if (edge_pend[2])
                edge_clr = 4'h4;
            else if (edge_pend[3])
                edge_clr = 4'h8;
        end
    end
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            pc_reg <= `DLBC_RESET_VECTOR;
            sp_reg <= 3'h0;
            cyc_reg <= 1'b0;
            instr_word <= 32'h0000_0000;
        end
        else if (advance)
        begin
            cyc_reg <= cplx_mode && !cyc_reg;
            if (instr_end)
            begin
                instr_word <= program_data_bus;
                if (nmi_pend_reg || (gen_irq_en && !int_n_s) || level_req || |edge_pend)
                begin
                    stack_reg[sp_reg] <= pc_reg;
                    sp_reg <= sp_reg + 3'h1;
                    if (nmi_pend_reg)
                        pc_reg <= `DLBC_NMI_VECTOR;
                    else if (gen_irq_en && !int_n_s)
                        pc_reg <= `DLBC_INT_VECTOR;
                    else if (level_req)
                        pc_reg <= `DLBC_LVL_VECTOR;
                    else if (edge_clr[0])
                        pc_reg <= `DLBC_EDGE0_VECTOR;
                    else if (edge_clr[1])
                        pc_reg <= `DLBC_EDGE0_VECTOR + 16'h1;
                    else if (edge_clr[2])
                        pc_reg <= `DLBC_EDGE0_VECTOR + 16'h2;
                    else
                        pc_reg <= `DLBC_EDGE0_VECTOR + 16'h3;
                end
                else if (rti_req)
                begin
                    pc_reg <= stack_reg[sp_reg - 3'h1];
                    sp_reg <= sp_reg - 3'h1;
                end
                else if (branch_req)
                    pc_reg <= branch_addr;
                else
                    pc_reg <= pc_reg + 16'h1;
            end
        end
    end
    // Program address and cycle marker; the marker falls as each instruction starts.
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            program_addr_bus <= 16'h0000;
            program_addr_oe_n <= 1'b0;
            instr_cycle_marker <= 1'b1;
        end
        else
        begin
            program_addr_bus <= pc_reg;
            program_addr_oe_n <= halt_s || dma_active || state_reg == DLBC_HALT;
            instr_cycle_marker <= !instr_end;
        end
    end
    property p_release_ack;
        @(posedge clk) disable iff (!rstn)
        !bus_release_ack_n |-> local_address_oe_n && &local_data_lines_oe_n;
    endproperty
    a_release_ack: assert property (p_release_ack)
        else $error("release acknowledge with bus driven");
    property p_addr_float;
        @(posedge clk) disable iff (!rstn)
        (hold_s || halt_s || lp_s) |=> local_address_oe_n;
    endproperty
    a_addr_float: assert property (p_addr_float)
        else $error("address driven during stop");
    property p_data_float;
        @(posedge clk) disable iff (!rstn)
        state_reg != DLBC_XFER |=> &local_data_lines_oe_n;
    endproperty
    a_data_float: assert property (p_data_float)
        else $error("data driven outside exchange");
    property p_request;
        @(posedge clk) disable iff (!rstn)
        !local_strobe_n |-> !local_bus_request_n;
    endproperty
    a_request: assert property (p_request)
        else $error("strobe without bus request");
    property p_clock;
        @(posedge clk) disable iff (!rstn)
        machine_clock_out |=> !machine_clock_out ##1 machine_clock_out;
    endproperty
    a_clock: assert property (p_clock)
        else $error("machine clock not half rate");
    sequence s_hold_access;
        state_reg == DLBC_HOLD && acc_req;
    endsequence
    property p_hold_halt;
        @(posedge clk) disable iff (!rstn)
        s_hold_access |=> state_reg == DLBC_HALT ##1 halted;
    endproperty
    a_hold_halt: assert property (p_hold_halt)
        else $error("access in hold did not halt");
    property p_prog_float;
        @(posedge clk) disable iff (!rstn)
        dma_active |=> program_addr_oe_n;
    endproperty
    a_prog_float: assert property (p_prog_float)
        else $error("program address driven during DMA");
    property p_nmi_vec;
        @(posedge clk) disable iff (!rstn)
        nmi_pend_reg && instr_end |=> pc_reg == `DLBC_NMI_VECTOR;
    endproperty
    a_nmi_vec: assert property (p_nmi_vec)
        else $error("NMI vector not loaded");
    property p_lowp_keep;
        @(posedge clk) disable iff (!rstn)
        state_reg == DLBC_LOWP |=> $stable(pc_reg);
    endproperty
    a_lowp_keep: assert property (p_lowp_keep)
        else $error("counter moved in low power");
endmodule : dlbc_core
`default_nettype wire

//--- verification/dlbc_mem_model.sv
// Behavioural local memory and program memory beside the core.
`default_nettype none
module dlbc_mem_model
    import dlbc_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic local_strobe_n,
    input wire logic local_rw,
    input wire logic [15:0] local_address_lines,
    input wire logic [15:0] local_data_lines_out,
    input wire logic [3:0] wait_cycles,
    input wire logic [15:0] program_addr_bus,
    output logic local_transfer_ack_n,
    output logic [15:0] mem_data,
    output logic [31:0] program_data_bus
);
    timeunit 1ns;
    timeprecision 1ps;
    dlbc_word_t mem [256];
    dlbc_word_t last_reg;
    logic drive_reg;
    logic [3:0] cnt_reg;
    // A released data bus shows the inverse of the last word, never a stale copy.
    assign mem_data = drive_reg ? last_reg : ~last_reg;
    assign program_data_bus = {~program_addr_bus, program_addr_bus};
    always @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            for (int i = 0; i < 256; i++)
                mem[i] <= 16'h5a00 | 16'(i);
            cnt_reg <= 4'h0;
            drive_reg <= 1'b0;
            last_reg <= 16'h0000;
            local_transfer_ack_n <= 1'b1;
        end
        else if (local_strobe_n)
        begin
            cnt_reg <= 4'h0;
            drive_reg <= 1'b0;
            local_transfer_ack_n <= 1'b1;
        end
        else if (cnt_reg < wait_cycles)
            cnt_reg <= cnt_reg + 4'h1;
        else if (local_transfer_ack_n)
        begin
            local_transfer_ack_n <= 1'b0;
            drive_reg <= local_rw;
            last_reg <= mem[local_address_lines[7:0]];
            if (!local_rw)
                mem[local_address_lines[7:0]] <= local_data_lines_out;
        end
    end
endmodule : dlbc_mem_model
`default_nettype wire

//--- verification/tb_top.sv
// Self-checking bench for the local bus and core control block.
`default_nettype none
module tb_top import dlbc_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic wr;
        dlbc_word_t addr;
        dlbc_word_t wdata;
        logic coef;
        logic [3:0] wt;
        dlbc_word_t exp_rd;
        logic exp_coef;
    } dlbc_row_s;
    localparam dlbc_row_s rows [7] = '{
        '{1'b1, 16'h0010, 16'h1234, 1'b0, 4'h1, 16'h0000, 1'b0},
        '{1'b0, 16'h0010, 16'h0000, 1'b0, 4'h1, 16'h1234, 1'b0},
        '{1'b0, 16'h0020, 16'h0000, 1'b0, 4'h5, 16'h5a20, 1'b0},
        '{1'b0, 16'h01ff, 16'h0000, 1'b1, 4'h0, 16'h5aff, 1'b1},
        '{1'b0, 16'h0200, 16'h0000, 1'b1, 4'h2, 16'h5a00, 1'b0},
        '{1'b1, 16'h01ff, 16'habcd, 1'b1, 4'h3, 16'h0000, 1'b1},
        '{1'b0, 16'h41ff, 16'h0000, 1'b0, 4'h1, 16'habcd, 1'b0}};
    logic clk, rstn, hold_req, halt_req, low_power_req, dma_active, local_transfer_ack_n;
    logic gen_irq_n, nmi_n, acc_req, acc_write, acc_coef, cplx_mode, irq_mode, gen_irq_en;
    logic branch_req, rti_req, local_rw, local_strobe_n, local_bus_request_n, hit;
    logic bus_release_ack_n, local_address_oe_n, machine_clock_out, program_addr_oe_n;
    logic coef_emulation_flag, instr_cycle_marker, acc_done, halted, prev;
    logic [3:0] wait_cycles;
    logic [7:0] general_port_pins_in, irq_mask, port_dir, port_wdata, general_port_pins_out;
    logic [7:0] general_port_pins_oe_n, port_test_cond;
    logic [15:0] local_data_lines_in, acc_addr, acc_wdata, branch_addr, local_data_lines_out;
    logic [15:0] local_data_lines_oe_n, local_address_lines, program_addr_bus, acc_rdata;
    logic [15:0] mem_data;
    logic [31:0] program_data_bus, instr_word;
    int fails, cmp_count, falls;
    assign local_data_lines_in = (~local_data_lines_oe_n & local_data_lines_out)
        | (local_data_lines_oe_n & mem_data);
    dlbc_core dut (.*);
    dlbc_mem_model mem_model (.*);
    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            fails++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk
    task automatic conclude;
        $display("Comparisons %0d, mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : conclude
    task automatic reset_check;
        @(posedge clk);
        rstn <= 1'b0;
        repeat (6) @(posedge clk);
        @(negedge clk);
        chk("rst_pc", program_addr_bus, 16'h0000);
        chk("rst_data_oe", local_data_lines_oe_n, 16'hffff);
        chk("rst_mclk", machine_clock_out, 1'b0);
        @(posedge clk);
        rstn <= 1'b1;
        repeat (3) @(posedge clk);
    endtask : reset_check
    task automatic xfer(input dlbc_row_s r);
        logic strb, req, drv, cf, rwv, done;
        logic [15:0] adr;
        {strb, req, drv, cf, done} = '0;
        {rwv, adr} = 'x;
        @(posedge clk);
        wait_cycles <= r.wt;
        acc_write <= r.wr;
        acc_addr <= r.addr;
        acc_wdata <= r.wdata;
        acc_coef <= r.coef;
        acc_req <= 1'b1;
        for (int i = 0; i < 40 && !done; i++)
        begin
            @(negedge clk);
            if (local_strobe_n === 1'b0)
            begin
                strb = 1'b1;
                rwv = local_rw;
                adr = local_address_lines;
            end
            req |= (local_bus_request_n === 1'b0);
            drv |= (local_data_lines_oe_n !== 16'hffff);
            cf |= (coef_emulation_flag === 1'b1);
            done = (acc_done === 1'b1);
        end
        chk("done", done, 1'b1);
        chk("strobe", strb, 1'b1);
        chk("request", req, 1'b1);
        chk("rw", rwv, !r.wr);
        chk("addr", adr, r.addr);
        chk("data_drive", drv, r.wr);
        chk("coef", cf, r.exp_coef);
        if (!r.wr)
            chk("rdata", acc_rdata, r.exp_rd);
        @(posedge clk);
        acc_req <= 1'b0;
    endtask : xfer
    task automatic count_marker;
        falls = 0;
        @(negedge clk);
        prev = instr_cycle_marker;
        repeat (8)
        begin
            @(negedge clk);
            if (prev === 1'b1 && instr_cycle_marker === 1'b0)
                falls++;
            prev = instr_cycle_marker;
        end
    endtask : count_marker
    // Parks the sequencer far above every vector, so a vector address proves an interrupt.
    task automatic fire(input int src, input logic [15:0] vec, input logic exp_hit, string nm);
        @(posedge clk);
        branch_addr <= 16'h8000;
        branch_req <= 1'b1;
        for (int i = 0; i < 20 && program_addr_bus[15] !== 1'b1; i++)
            @(negedge clk);
        @(posedge clk);
        branch_req <= 1'b0;
        if (src < 8)
            general_port_pins_in[src] <= 1'b0;
        else if (src == 8)
            gen_irq_n <= 1'b0;
        else
            nmi_n <= 1'b0;
        hit = 1'b0;
        for (int i = 0; i < 30 && !hit; i++)
        begin
            @(negedge clk);
            hit = (program_addr_bus === vec);
        end
        @(posedge clk);
        general_port_pins_in <= 8'hff;
        {gen_irq_n, nmi_n} <= 2'b11;
        chk(nm, hit, exp_hit);
    endtask : fire
    initial
    begin
        repeat (6000) @(posedge clk);
        fails++;
        conclude();
    end
    initial
    begin
        rstn = 1'b0;
        {hold_req, halt_req, low_power_req, dma_active, acc_req, acc_write, acc_coef} = '0;
        {cplx_mode, irq_mode, gen_irq_en, branch_req, rti_req, gen_irq_n, nmi_n} = 7'h03;
        {general_port_pins_in, irq_mask, port_dir, port_wdata} = 32'hff000000;
        {acc_addr, acc_wdata, branch_addr} = '0;
        wait_cycles = 4'h1;
        reset_check();
        foreach (rows[i])
            xfer(rows[i]);
        @(negedge clk);
        prev = machine_clock_out;
        repeat (6)
        begin
            @(negedge clk);
            chk("mclk", machine_clock_out, !prev);
            prev = machine_clock_out;
        end
        count_marker();
        chk("marker", falls != 0, 1'b1);
        chk("instr", {16'h0, instr_word[31:16]}, {16'h0, ~instr_word[15:0]});
        @(posedge clk);
        hold_req <= 1'b1;
        for (int i = 0; i < 20 && bus_release_ack_n !== 1'b0; i++)
            @(negedge clk);
        chk("hold_ack", bus_release_ack_n, 1'b0);
        chk("hold_addr_oe", local_address_oe_n, 1'b1);
        chk("hold_data_oe", local_data_lines_oe_n, 16'hffff);
        @(posedge clk);
        acc_write <= 1'b0;
        acc_req <= 1'b1;
        for (int i = 0; i < 20 && halted !== 1'b1; i++)
            @(negedge clk);
        chk("hold_halt", halted, 1'b1);
        chk("hold_strobe", local_strobe_n, 1'b1);
        @(posedge clk);
        acc_req <= 1'b0;
        hold_req <= 1'b0;
        for (int i = 0; i < 20 && halted !== 1'b0; i++)
            @(negedge clk);
        chk("hold_exit", {halted, bus_release_ack_n}, 2'b01);
        @(posedge clk);
        halt_req <= 1'b1;
        for (int i = 0; i < 20 && halted !== 1'b1; i++)
            @(negedge clk);
        chk("halt_oe", {program_addr_oe_n, local_address_oe_n}, 2'b11);
        count_marker();
        chk("halt_marker", falls, 0);
        @(posedge clk);
        halt_req <= 1'b0;
        low_power_req <= 1'b1;
        repeat (6) @(negedge clk);
        chk("lp_addr_oe", local_address_oe_n, 1'b1);
        chk("lp_data_oe", local_data_lines_oe_n, 16'hffff);
        count_marker();
        chk("lp_marker", falls, 0);
        @(posedge clk);
        low_power_req <= 1'b0;
        repeat (6) @(negedge clk);
        chk("run_pa_oe", program_addr_oe_n, 1'b0);
        @(posedge clk);
        dma_active <= 1'b1;
        repeat (2) @(negedge clk);
        chk("dma_pa_oe", program_addr_oe_n, 1'b1);
        @(posedge clk);
        dma_active <= 1'b0;
        reset_check();
        @(posedge clk);
        port_dir <= 8'h0f;
        port_wdata <= 8'ha5;
        general_port_pins_in <= 8'h3c;
        repeat (5) @(negedge clk);
        chk("port_oe", general_port_pins_oe_n, 8'hf0);
        chk("port_out", general_port_pins_out[3:0], 4'h5);
        chk("port_test", port_test_cond, 8'h3c);
        @(posedge clk);
        irq_mode <= 1'b1;
        general_port_pins_in <= 8'hff;
        irq_mask <= 8'hff;
        gen_irq_en <= 1'b1;
        repeat (4) @(negedge clk);
        chk("port_irq_oe", general_port_pins_oe_n, 8'hff);
        fire(0, 16'h0006, 1'b1, "irq_edge0");
        fire(3, 16'h0009, 1'b1, "irq_edge3");
        fire(4, 16'h0005, 1'b1, "irq_level4");
        fire(8, 16'h0001, 1'b1, "irq_gen");
        @(posedge clk);
        irq_mask <= 8'h00;
        gen_irq_en <= 1'b0;
        fire(1, 16'h0007, 1'b0, "irq_edge1_masked");
        fire(8, 16'h0001, 1'b0, "irq_gen_masked");
        fire(9, 16'h000a, 1'b1, "irq_nmi");
        conclude();
    end
endmodule : tb_top
`default_nettype wire
